// file: src/cfw_pkg.sv
package cfw_pkg;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int CFG_POWER_BIT   = 0;
	localparam int CFG_LED_BIT     = 1;
	localparam int CFG_RWAKE_BIT   = 2;
	localparam int PME_SRC_BIT     = 2;
	localparam int PME_POL_BIT     = 4;
	localparam int PME_LEN_BIT     = 5;
	localparam int PME_FORM_BIT    = 6;
	localparam int PME_EN_BIT      = 7;
	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] PME_RESET = 8'h00;
	localparam int CLK_HZ          = 10_000_000;
	localparam int PULSE_SHORT_US  = 1500;
	localparam int PULSE_LONG_US   = 150_000;
	localparam int PULSE_SHORT_CYC = PULSE_SHORT_US * (CLK_HZ / 1_000_000);
	localparam int PULSE_LONG_CYC  = PULSE_LONG_US * (CLK_HZ / 1_000_000);

	// LED pin roles
	typedef enum logic [1:0] {
		cfw_led_off_type_speed,
		cfw_led_linkact,
		cfw_led_link,
		cfw_led_act
	} cfw_led_role_type;

	// Wake events from the detection logic
	typedef struct packed {
		logic pin_event;
		logic pattern_frame;
		logic link_up;
	} cfw_wake_evt_type;
endpackage : cfw_pkg

// file: src/cfw_decode.sv
`timescale 1ns/1ns
module cfw_decode #(
	parameter int LONG_CYC  = cfw_pkg::PULSE_LONG_CYC,
	parameter int SHORT_CYC = cfw_pkg::PULSE_SHORT_CYC
) (
	// Clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	input  wire logic                      clk_en,
	// Loaded configuration
	input  wire logic                      cfg_load,
	input  wire logic [7:0]                cfg_flags,
	input  wire logic [7:0]                pme_flags,
	input  wire logic                      desc_present,
	input  wire logic                      desc_remote_wake,
	input  wire logic                      desc_self_power,
	// Pins and events
	input  wire logic                      remote_wake_strap,
	input  wire logic                      phy_source_select,
	input  wire cfw_pkg::cfw_wake_evt_type wake_evt,
	// LED sources
	input  wire logic                      led_speed,
	input  wire logic                      led_link,
	input  wire logic                      led_act,
	input  wire logic                      led_fdx,
	// Decoded outputs
	output logic                           speed_led_pin,
	output logic                           link_activity_led_pin,
	output logic                           duplex_led_pin,
	output logic                           self_powered,
	output logic                           remote_wake_support,
	output logic                           wake_pin_internal_phy_o,
	output logic                           wake_pin_internal_phy_oe,
	output logic                           wake_pin_external_phy_o,
	output logic                           wake_pin_external_phy_oe
);
	// Counter is 24 bits wide, so longer pulses cannot be served
	if (SHORT_CYC < 1 || LONG_CYC <= SHORT_CYC || LONG_CYC >= (1 << 24)) begin : g_bad_counts
		$error("cfw_decode: bad pulse counts");
	end

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [1:0] strap_sync;
	logic [1:0] phy_sync;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			strap_sync <= 2'h0;
			phy_sync   <= 2'h0;
		end else if (clk_en) begin
			strap_sync <= {strap_sync[0], remote_wake_strap};
			phy_sync   <= {phy_sync[0], phy_source_select};
		end
	end
	wire strap_s  = strap_sync[1];
	wire ext_phy  = phy_sync[1];

	// ****************************************
	// Configuration capture
	// ****************************************
	logic [7:0] cfg;
	logic [7:0] pme;
	logic       loaded;
	// Strap only counts until a flag byte arrives
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cfg    <= cfw_pkg::CFG_RESET;
			pme    <= cfw_pkg::PME_RESET;
			loaded <= 1'b0;
		end else if (clk_en && cfg_load) begin
			cfg    <= cfg_flags;
			pme    <= pme_flags;
			loaded <= 1'b1;
		end
	end

	// Precedence: descriptor, then flag byte, then strap
	wire flag_rwake     = loaded ? cfg[cfw_pkg::CFG_RWAKE_BIT] : strap_s;
	wire next_rwake     = desc_present ? desc_remote_wake : flag_rwake;
	wire next_selfpower = desc_present ? desc_self_power : cfg[cfw_pkg::CFG_POWER_BIT];
	wire led_alt        = cfg[cfw_pkg::CFG_LED_BIT];
	wire next_lnk_led   = led_alt ? led_link : (led_link & led_act);
	wire next_fdx_led   = led_alt ? led_act : led_fdx;

	// ****************************************
	// Wake decode
	// ****************************************
	wire pme_en    = pme[cfw_pkg::PME_EN_BIT];
	wire pme_pulse = pme[cfw_pkg::PME_FORM_BIT];
	wire pme_long  = pme[cfw_pkg::PME_LEN_BIT];
	wire pme_pol   = pme[cfw_pkg::PME_POL_BIT];
	wire pme_link  = pme[cfw_pkg::PME_SRC_BIT];
	// Link-up source is dead with an external PHY
	wire src_evt   = pme_link ? (wake_evt.link_up & ~ext_phy) : wake_evt.pattern_frame;
	wire wake_evt_any = pme_en & (wake_evt.pin_event | src_evt);
	wire [23:0] pulse_len = pme_long ? 24'(LONG_CYC) : 24'(SHORT_CYC);

	logic        level_on;
	logic [23:0] pulse_cnt;
	// Level holds until reset or reload; pulse fires once per event, retrigger ignored
	always_ff @(posedge clk_sys) begin
		if (!rst_n || (clk_en && cfg_load)) begin
			level_on  <= 1'b0;
			pulse_cnt <= 24'h0;
		end else if (clk_en) begin
			if (wake_evt_any && !pme_pulse)
				level_on <= 1'b1;
			if (pulse_cnt != 24'h0)
				pulse_cnt <= pulse_cnt - 24'h1;
			else if (wake_evt_any && pme_pulse)
				pulse_cnt <= pulse_len;
		end
	end
	wire active      = pme_en & (pme_pulse ? (pulse_cnt != 24'h0) : level_on);
	wire next_wake_o = active ? pme_pol : ~pme_pol;
	wire next_int_oe = pme_en & ~ext_phy;
	wire next_ext_oe = pme_en & ext_phy;

	// ****************************************
	// Output registers
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			speed_led_pin            <= 1'b0;
			link_activity_led_pin    <= 1'b0;
			duplex_led_pin           <= 1'b0;
			self_powered             <= 1'b0;
			remote_wake_support      <= 1'b0;
			wake_pin_internal_phy_o  <= 1'b0;
			wake_pin_internal_phy_oe <= 1'b0;
			wake_pin_external_phy_o  <= 1'b0;
			wake_pin_external_phy_oe <= 1'b0;
		end else if (clk_en) begin
			speed_led_pin            <= led_speed;
			link_activity_led_pin    <= next_lnk_led;
			duplex_led_pin           <= next_fdx_led;
			self_powered             <= next_selfpower;
			remote_wake_support      <= next_rwake;
			wake_pin_internal_phy_o  <= next_wake_o & next_int_oe;
			wake_pin_internal_phy_oe <= next_int_oe;
			wake_pin_external_phy_o  <= next_wake_o & next_ext_oe;
			wake_pin_external_phy_oe <= next_ext_oe;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_desc_wins;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && desc_present && $stable(desc_present)) |=> (remote_wake_support == $past(desc_remote_wake));
	endproperty
	a_desc_wins: assert property (p_desc_wins) else $error("descriptor not preferred");
	property p_flag_over_strap;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && loaded && !desc_present) |=> (remote_wake_support == $past(cfg[cfw_pkg::CFG_RWAKE_BIT]));
	endproperty
	a_flag_over_strap: assert property (p_flag_over_strap) else $error("strap overrode flag");
	property p_power;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && !desc_present) |=> (self_powered == $past(cfg[0]));
	endproperty
	a_power: assert property (p_power) else $error("power method wrong");
	property p_led_alt;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && led_alt) |=> (duplex_led_pin == $past(led_act));
	endproperty
	a_led_alt: assert property (p_led_alt) else $error("led role wrong");
	property p_disabled_quiet;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && !pme_en) |=> !wake_pin_internal_phy_oe && !wake_pin_external_phy_oe;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("wake driven while off");
	property p_route;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && pme_en) |=> (wake_pin_external_phy_oe == $past(ext_phy)) && (wake_pin_internal_phy_oe != $past(ext_phy));
	endproperty
	a_route: assert property (p_route) else $error("wake on wrong pin");
	property p_pulse_start;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && !cfg_load && wake_evt_any && pme_pulse && pulse_cnt == 24'h0) |=> (pulse_cnt == $past(pulse_len));
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("pulse length wrong");
	property p_level_sticks;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && !cfg_load && wake_evt_any && !pme_pulse) |=> level_on;
	endproperty
	a_level_sticks: assert property (p_level_sticks) else $error("level not held");
	property p_polarity;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && pme_en && !ext_phy) |=>
			(wake_pin_internal_phy_o == ($past(active) ? $past(pme_pol) : ~$past(pme_pol)));
	endproperty
	a_polarity: assert property (p_polarity) else $error("wake polarity wrong");
	c_level: cover property (@(posedge clk_sys) disable iff (!rst_n) wake_evt_any && !pme_pulse);
	c_pulse: cover property (@(posedge clk_sys) disable iff (!rst_n) wake_evt_any && pme_pulse && pme_long);
	c_ext:   cover property (@(posedge clk_sys) disable iff (!rst_n) wake_pin_external_phy_oe);
endmodule : cfw_decode

// file: test/cfw_host_model.sv
`timescale 1ns/1ns
// Host wake input: sees the selected pin and times each assertion
module cfw_host_model (
	// Pin and expected polarity
	input  wire logic clk_sys,
	input  wire logic pin_o,
	input  wire logic pin_oe,
	input  wire logic pol,
	// What the host saw
	output logic      active,
	output int        width
);
	int run;
	// A released pin is pulled to the idle level, so float never reads as a wake
	assign active = ((pin_oe ? pin_o : ~pol) == pol);
	// Latch the length of the last assertion when it ends
	always_ff @(posedge clk_sys) begin
		run <= active ? run + 1 : 0;
		if (!active && run != 0) width <= run;
	end
endmodule : cfw_host_model

// file: test/tb_config_flag_pme_wake_decode.sv
`timescale 1ns/1ns
module tb_config_flag_pme_wake_decode;
	// ****************************************
	// Signals
	// ****************************************
	localparam int SHORT = 5;
	localparam int LONG  = 20;
	logic clk_sys, rst_n, clk_en, cfg_load, desc_present, desc_remote_wake, desc_self_power;
	logic remote_wake_strap, phy_source_select, led_speed, led_link, led_act, led_fdx;
	logic [7:0] cfg_flags, pme_flags, p;
	logic [31:0] r;
	cfw_pkg::cfw_wake_evt_type wake_evt;
	logic spd, lnk, dpx, self_powered, remote_wake_support, wi_o, wi_oe, we_o, we_oe, active;
	int width, error_cnt, tests_run, cycles, seed, i;
	cfw_decode #(.LONG_CYC(LONG), .SHORT_CYC(SHORT)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.clk_en(clk_en), .cfg_load(cfg_load), .cfg_flags(cfg_flags), .pme_flags(pme_flags),
		.desc_present(desc_present), .desc_remote_wake(desc_remote_wake), .desc_self_power(desc_self_power),
		.remote_wake_strap(remote_wake_strap), .phy_source_select(phy_source_select), .wake_evt(wake_evt),
		.led_speed(led_speed), .led_link(led_link), .led_act(led_act), .led_fdx(led_fdx),
		.speed_led_pin(spd), .link_activity_led_pin(lnk), .duplex_led_pin(dpx),
		.self_powered(self_powered), .remote_wake_support(remote_wake_support),
		.wake_pin_internal_phy_o(wi_o), .wake_pin_internal_phy_oe(wi_oe),
		.wake_pin_external_phy_o(we_o), .wake_pin_external_phy_oe(we_oe));
	cfw_host_model u_host (.clk_sys(clk_sys), .pin_o(phy_source_select ? we_o : wi_o),
		.pin_oe(phy_source_select ? we_oe : wi_oe), .pol(pme_flags[4]), .active(active), .width(width));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Selects settle through the pin synchronisers before the load
	task automatic load(input logic [7:0] c, input logic [7:0] m, input logic s);
		cfg_flags <= c;
		pme_flags <= m;
		phy_source_select <= s;
		repeat (4) @(posedge clk_sys);
		cfg_load <= 1'b1;
		@(posedge clk_sys);
		cfg_load <= 1'b0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : load
	task automatic cfg_case(input logic [7:0] c, input logic d);
		@(posedge clk_sys);
		r = $random(seed);
		{led_speed, led_link, led_act, led_fdx} <= r[3:0];
		desc_present <= d;
		desc_self_power <= ~c[0];
		desc_remote_wake <= ~c[2];
		load(c, 8'h00, 1'b0);
		chk(self_powered, c[0] ^ d);
		chk(remote_wake_support, c[2] ^ d);
		chk(spd, led_speed);
		chk(lnk, c[1] ? led_link : led_link & led_act);
		chk(dpx, c[1] ? led_act : led_fdx);
	endtask : cfg_case
	// Event index: 0 link-up, 1 pattern frame, 2 wake pin
	task automatic wake_case(input logic [7:0] m, input logic s, input int ev);
		logic exp;
		exp = m[7] && (ev == 2 || (ev == 1 && !m[2]) || (ev == 0 && m[2] && !s));
		@(posedge clk_sys);
		load(8'h00, m, s);
		chk(s ? we_oe : wi_oe, m[7]);
		chk(s ? wi_oe : we_oe, 1'b0);
		chk(active, 1'b0);
		@(posedge clk_sys);
		wake_evt <= cfw_pkg::cfw_wake_evt_type'(3'b001 << ev);
		@(posedge clk_sys);
		wake_evt <= '0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(active, exp);
		repeat (LONG + 2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(active, exp && !m[6]);
		if (exp && m[6]) chk(8'(width), m[5] ? LONG : SHORT);
	endtask : wake_case
	// Enable low must freeze the registers; checked on the speed_led_pin output only
	task automatic freeze_case;
		logic held;
		@(posedge clk_sys);
		held = led_speed;
		clk_en <= 1'b0;
		led_speed <= !held;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(spd, held);
		@(posedge clk_sys);
		clk_en <= 1'b1;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(spd, !held);
	endtask : freeze_case
	task automatic tally_and_finish;
		$display("errors=%0d checks=%0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	// ****************************************
	// Clock, timeout and main sequence
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Whole run needs about 1390 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial begin
		seed = 32'h65633a81;
		{rst_n, cfg_load, desc_present, desc_remote_wake, desc_self_power, phy_source_select} = '0;
		{led_speed, led_link, led_act, led_fdx} = '0;
		{cfg_flags, pme_flags} = '0;
		wake_evt = '0;
		clk_en = 1'b1;
		remote_wake_strap = 1'b1;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (6) @(negedge clk_sys);
		chk(remote_wake_support, 1'b1);
		for (i = 0; i < 16; i++) begin
			r = $random(seed);
			cfg_case({r[7:3], i[2:0]}, i[3]);
		end
		freeze_case();
		for (i = 0; i < 3; i++) wake_case(8'h7f, i[0], i);
		wake_case(8'h84, 1'b1, 0);
		for (i = 0; i < 30; i++) begin
			r = $random(seed);
			p = r[7:0];
			if (i < 16) p[7:4] = {1'b1, i[2:0]};
			wake_case(p, i[3] ^ r[9], i % 3);
		end
		tally_and_finish();
	end
endmodule : tb_config_flag_pme_wake_decode
